// >>> rtl/adc_seq_pkg.sv
/*
 Constants, register map and state encoding for the converter sequencing block.
 Assumes one converter state equals one cycle of the 200 MHz system clock.
*/
package adc_seq_pkg;

	// =====================================================================
	// Register map
	localparam logic [15:0] ADDR_RESULT_A = 16'hFFE0;
	localparam logic [15:0] ADDR_RESULT_B = 16'hFFE2;
	localparam logic [15:0] ADDR_RESULT_C = 16'hFFE4;
	localparam logic [15:0] ADDR_RESULT_D = 16'hFFE6;
	localparam logic [15:0] ADDR_CTRL_STATUS = 16'hFFE8;
	localparam logic [15:0] ADDR_TRIG_CTRL = 16'hFFEA;

	// =====================================================================
	// Reset values and field positions
	localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
	localparam logic [7:0] TRIG_CTRL_RESET = 8'h7E;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic [7:0] TRIG_FIXED_ONES = 8'h7E;
	localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;
	localparam int CS_DONE = 7;
	localparam int CS_IRQ_ALLOW = 6;
	localparam int CS_GO = 5;
	localparam int CS_SCAN = 4;
	localparam int CS_SPEED = 3;
	localparam int CS_GROUP = 2;
	localparam int TC_ALLOW = 7;
	localparam int TC_SPARE = 0;

	// =====================================================================
	// Timing in converter states
	localparam int SYNC_MIN_SLOW = 18;
	localparam int SYNC_MAX_SLOW = 33;
	localparam int SYNC_MIN_FAST = 10;
	localparam int SYNC_MAX_FAST = 17;
	localparam int SAMPLE_SLOW = 63;
	localparam int SAMPLE_FAST = 31;
	localparam int SINGLE_MIN_SLOW = 227;
	localparam int SINGLE_MIN_FAST = 115;
	localparam int SCAN_FIRST_MIN_SLOW = 259;
	localparam int SCAN_FIRST_MIN_FAST = 131;
	localparam int SCAN_NEXT_SLOW = 256;
	localparam int SCAN_NEXT_FAST = 128;
	localparam int SAR_STEPS = 8;

	// Counter loads: a phase with load L lasts L+1 cycles.
	localparam logic [7:0] SYNC_LOAD_SLOW = 8'(SYNC_MIN_SLOW - 2);
	localparam logic [7:0] SYNC_LOAD_FAST = 8'(SYNC_MIN_FAST - 2);
	localparam logic [7:0] SPREAD_SLOW = 8'(SYNC_MAX_SLOW - SYNC_MIN_SLOW);
	localparam logic [7:0] SPREAD_FAST = 8'(SYNC_MAX_FAST - SYNC_MIN_FAST);
	localparam logic [7:0] SAMPLE_LOAD_SLOW = 8'(SAMPLE_SLOW - 1);
	localparam logic [7:0] SAMPLE_LOAD_FAST = 8'(SAMPLE_FAST - 1);
	localparam logic [7:0] CONV_SINGLE_SLOW = 8'(SINGLE_MIN_SLOW - SYNC_MIN_SLOW - SAMPLE_SLOW - 1);
	localparam logic [7:0] CONV_SINGLE_FAST = 8'(SINGLE_MIN_FAST - SYNC_MIN_FAST - SAMPLE_FAST - 1);
	localparam logic [7:0] CONV_FIRST_SLOW =
		8'(SCAN_FIRST_MIN_SLOW - SYNC_MIN_SLOW - SAMPLE_SLOW - 1);
	localparam logic [7:0] CONV_FIRST_FAST =
		8'(SCAN_FIRST_MIN_FAST - SYNC_MIN_FAST - SAMPLE_FAST - 1);
	localparam logic [7:0] CONV_NEXT_SLOW = 8'(SCAN_NEXT_SLOW - SAMPLE_SLOW - 1);
	localparam logic [7:0] CONV_NEXT_FAST = 8'(SCAN_NEXT_FAST - SAMPLE_FAST - 1);
	localparam logic [7:0] SAR_LAST_STEP = 8'(SAR_STEPS - 1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SYNC = 2'b01,
		ST_SAMPLE = 2'b11,
		ST_CONVERT = 2'b10
	} seq_state_t;

endpackage

// >>> rtl/adc_sequence_control.sv
/*
 Sequencing and register logic of an 8-bit successive-approximation converter.
 Assumes an external comparator that reports analog input >= sar_code, a plain
 register port with read data one cycle later, and a synchronous standby input.
*/
// What this block does
// R1: Trigger control resets to 7E, also standby.
// R2: Trigger allow bit gates external start pin.
// R3: Trigger control bits 6..1 read one.
// R4: Spare bit is stored, has no effect.
// R5: Eight approximation steps give code 00..FF.
// R6: Single mode: go held, cleared at end.
// R7: Single end sets done, irq if allowed.
// R8: Done clears on standby or after read then zero-write.
// R9: Single end: store result, done, stop.
// R10: Software stops go before changing settings.
// R11: One write may set fields and go.
// R12: Scan starts at group's first channel.
// R13: Scan: next channel follows immediately.
// R14: Scan pass end: done, irq, restart.
// R15: Scan repeats; restart always at first channel.
// R16: Sync delay, then 63 or 31 sample.
// R17: Sync delay 18..33 or 10..17 states.
// R18: Single total 227..242 or 115..122 states.
// R19: Scan first 259..274 or 131..138 states.
// R20: Scan later conversions 256 or 128 states.
// R21: Pin falling edge sets go when allowed.
// R22: Done bit: write zero clears, one ignored.
// R23: Channel bits: input or group and count.
// R24: Result register shared by inputs n, n+4.
// R25: Control/status resets to 00, stops conversion.
// R26: Start pin synchronised, edge from samples.
// R27: Clearing go aborts, no result, flag kept.
`timescale 1ns/1ps
module adc_sequence_control (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic standby,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic ext_start_pin_n,
	input wire logic comp_in,
	output logic [7:0] sar_code,
	output logic [2:0] analog_sel,
	output logic sample_hold,
	output logic convert_done_irq
);

	// =====================================================================
	// Declarations
	logic convert_done_flag_q, convert_done_flag_d;
	logic done_irq_allow_q, done_irq_allow_d;
	logic convert_go_q, convert_go_d;
	logic scan_q, scan_d;
	logic conv_speed_select_q, conv_speed_select_d;
	logic [2:0] ch_sel_q, ch_sel_d;
	logic ext_trigger_allow_q, ext_trigger_allow_d;
	logic spare_select_bit_q, spare_select_bit_d;
	logic armed_q, armed_d;
	logic irq_q, irq_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] res_q [4];
	logic [7:0] res_d [4];
	adc_seq_pkg::seq_state_t state_q, state_d;
	logic [7:0] cnt_q, cnt_d;
	logic [1:0] cur_q, cur_d;
	logic first_q, first_d;
	logic [7:0] sar_q, sar_d;
	logic hold_q, hold_d;
	logic [7:0] hold_run_q, hold_run_d;
	logic [2:0] sel_q, sel_d;
	logic [3:0] ph_q;
	logic pin_s1_q, pin_s2_q, pin_prev_q;
	logic conv_end, done_set, single_end, trig_fire;
	logic wr_cs, rd_cs, wr_tc;
	logic [7:0] spread;
	logic [2:0] step;

	// Result register and channel within the group driven by the current conversion.
	function automatic logic [1:0] slot_of(input logic scan, input logic [2:0] ch,
		input logic [1:0] cur);
		slot_of = scan ? cur : ch[1:0];
	endfunction

	assign wr_cs = reg_wr && (reg_addr == adc_seq_pkg::ADDR_CTRL_STATUS);
	assign rd_cs = reg_rd && (reg_addr == adc_seq_pkg::ADDR_CTRL_STATUS);
	assign wr_tc = reg_wr && (reg_addr == adc_seq_pkg::ADDR_TRIG_CTRL);

	// =====================================================================
	// External start pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
			pin_prev_q <= 1'b1;
			ph_q <= 4'h0;
		end else begin
			pin_s1_q <= ext_start_pin_n; // [R26]
			pin_s2_q <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
			ph_q <= ph_q + 4'h1;
		end
	end

	assign trig_fire = pin_prev_q && !pin_s2_q && ext_trigger_allow_q; // [R2] [R21] [R26]

	// =====================================================================
	// Sequencer
	// The free-running phase stretches the sync delay so that sampling
	// starts on a fixed phase of the conversion timing.
	assign spread = conv_speed_select_q ? ({4'h0, ~ph_q} & adc_seq_pkg::SPREAD_FAST)
		: ({4'h0, ~ph_q} & adc_seq_pkg::SPREAD_SLOW); // [R17]
	assign step = cnt_q[2:0];

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		cur_d = cur_q;
		first_d = first_q;
		sar_d = sar_q;
		hold_d = 1'b0;
		conv_end = 1'b0;
		res_d = res_q;
		hold_run_d = hold_q ? hold_run_q + 8'h01 : 8'h00;
		if (cnt_q != 8'h00) begin
			cnt_d = cnt_q - 8'h01;
		end
		if (standby) begin
			state_d = adc_seq_pkg::ST_IDLE;
			for (int i = 0; i < 4; i++) begin
				res_d[i] = adc_seq_pkg::RESULT_RESET;
			end
		end else if (!convert_go_q) begin
			state_d = adc_seq_pkg::ST_IDLE; // [R27] [R25]
		end else begin
			unique case (state_q)
				adc_seq_pkg::ST_IDLE: begin
					state_d = adc_seq_pkg::ST_SYNC; // [R11]
					cur_d = 2'b00; // [R12] [R15]
					first_d = 1'b1;
					cnt_d = (conv_speed_select_q ? adc_seq_pkg::SYNC_LOAD_FAST
						: adc_seq_pkg::SYNC_LOAD_SLOW) + spread; // [R17]
				end
				adc_seq_pkg::ST_SYNC: begin
					if (cnt_q == 8'h00) begin
						state_d = adc_seq_pkg::ST_SAMPLE; // [R16]
						hold_d = 1'b1;
						cnt_d = conv_speed_select_q ? adc_seq_pkg::SAMPLE_LOAD_FAST
							: adc_seq_pkg::SAMPLE_LOAD_SLOW;
					end
				end
				adc_seq_pkg::ST_SAMPLE: begin
					hold_d = (cnt_q != 8'h00);
					if (cnt_q == 8'h00) begin
						state_d = adc_seq_pkg::ST_CONVERT;
						sar_d = adc_seq_pkg::SAR_FIRST_TRIAL;
						if (!scan_q) begin
							cnt_d = conv_speed_select_q ? adc_seq_pkg::CONV_SINGLE_FAST
								: adc_seq_pkg::CONV_SINGLE_SLOW; // [R18]
						end else if (first_q) begin
							cnt_d = conv_speed_select_q ? adc_seq_pkg::CONV_FIRST_FAST
								: adc_seq_pkg::CONV_FIRST_SLOW; // [R19]
						end else begin
							cnt_d = conv_speed_select_q ? adc_seq_pkg::CONV_NEXT_FAST
								: adc_seq_pkg::CONV_NEXT_SLOW; // [R20]
						end
					end
				end
				adc_seq_pkg::ST_CONVERT: begin
					if (cnt_q <= adc_seq_pkg::SAR_LAST_STEP) begin
						// One decision per cycle, most significant bit first.
						if (!comp_in) begin
							sar_d[step] = 1'b0; // [R5]
						end
						if (step != 3'h0) begin
							sar_d[step - 3'h1] = 1'b1;
						end
					end
					if (cnt_q == 8'h00) begin
						conv_end = 1'b1;
						res_d[slot_of(scan_q, ch_sel_q, cur_q)] = sar_d; // [R9] [R24]
						if (!scan_q) begin
							state_d = adc_seq_pkg::ST_IDLE; // [R9]
						end else begin
							state_d = adc_seq_pkg::ST_SAMPLE; // [R13] [R20]
							hold_d = 1'b1;
							first_d = 1'b0;
							cnt_d = conv_speed_select_q ? adc_seq_pkg::SAMPLE_LOAD_FAST
								: adc_seq_pkg::SAMPLE_LOAD_SLOW;
							cur_d = (cur_q == ch_sel_q[1:0]) ? 2'b00 : cur_q + 2'b01; // [R14] [R23]
						end
					end
				end
			endcase
		end
		sel_d = {ch_sel_q[adc_seq_pkg::CS_GROUP], slot_of(scan_q, ch_sel_q, cur_d)}; // [R23]
	end

	assign done_set = conv_end && (!scan_q || cur_q == ch_sel_q[1:0]); // [R7] [R14]
	assign single_end = conv_end && !scan_q; // [R6]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= adc_seq_pkg::ST_IDLE;
			cnt_q <= 8'h00;
			cur_q <= 2'b00;
			first_q <= 1'b0;
			sar_q <= 8'h00;
			hold_q <= 1'b0;
			hold_run_q <= 8'h00;
			sel_q <= 3'h0;
			for (int i = 0; i < 4; i++) begin
				res_q[i] <= adc_seq_pkg::RESULT_RESET;
			end
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			cur_q <= cur_d;
			first_q <= first_d;
			sar_q <= sar_d;
			hold_q <= hold_d;
			hold_run_q <= hold_run_d;
			sel_q <= sel_d;
			res_q <= res_d;
		end
	end

	// =====================================================================
	// Control registers
	always_comb begin
		convert_done_flag_d = convert_done_flag_q;
		done_irq_allow_d = done_irq_allow_q;
		convert_go_d = convert_go_q;
		scan_d = scan_q;
		conv_speed_select_d = conv_speed_select_q;
		ch_sel_d = ch_sel_q;
		ext_trigger_allow_d = ext_trigger_allow_q;
		spare_select_bit_d = spare_select_bit_q;
		armed_d = armed_q;
		if (standby) begin
			{convert_done_flag_d, done_irq_allow_d, convert_go_d, scan_d,
				conv_speed_select_d, ch_sel_d} = adc_seq_pkg::CTRL_STATUS_RESET; // [R25]
			ext_trigger_allow_d = adc_seq_pkg::TRIG_CTRL_RESET[adc_seq_pkg::TC_ALLOW]; // [R1]
			spare_select_bit_d = adc_seq_pkg::TRIG_CTRL_RESET[adc_seq_pkg::TC_SPARE];
			armed_d = 1'b0;
		end else begin
			if (rd_cs && convert_done_flag_q) begin
				armed_d = 1'b1; // [R8]
			end
			if (single_end) begin
				convert_go_d = 1'b0; // [R6]
			end
			if (wr_cs) begin
				armed_d = 1'b0;
				if (armed_q && !reg_wdata[adc_seq_pkg::CS_DONE]) begin
					convert_done_flag_d = 1'b0; // [R8] [R22]
				end
				done_irq_allow_d = reg_wdata[adc_seq_pkg::CS_IRQ_ALLOW];
				convert_go_d = reg_wdata[adc_seq_pkg::CS_GO]; // [R11] [R15]
				scan_d = reg_wdata[adc_seq_pkg::CS_SCAN];
				conv_speed_select_d = reg_wdata[adc_seq_pkg::CS_SPEED];
				ch_sel_d = reg_wdata[adc_seq_pkg::CS_GROUP:0];
			end
			if (wr_tc) begin
				ext_trigger_allow_d = reg_wdata[adc_seq_pkg::TC_ALLOW]; // [R2]
				spare_select_bit_d = reg_wdata[adc_seq_pkg::TC_SPARE]; // [R4]
			end
			if (trig_fire) begin
				convert_go_d = 1'b1; // [R21]
			end
			if (done_set) begin
				convert_done_flag_d = 1'b1; // [R7] [R14]
			end
		end
		irq_d = convert_done_flag_d && done_irq_allow_d; // [R7]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{convert_done_flag_q, done_irq_allow_q, convert_go_q, scan_q,
				conv_speed_select_q, ch_sel_q} <= adc_seq_pkg::CTRL_STATUS_RESET; // [R25]
			ext_trigger_allow_q <= adc_seq_pkg::TRIG_CTRL_RESET[adc_seq_pkg::TC_ALLOW]; // [R1]
			spare_select_bit_q <= adc_seq_pkg::TRIG_CTRL_RESET[adc_seq_pkg::TC_SPARE];
			armed_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			convert_done_flag_q <= convert_done_flag_d;
			done_irq_allow_q <= done_irq_allow_d;
			convert_go_q <= convert_go_d;
			scan_q <= scan_d;
			conv_speed_select_q <= conv_speed_select_d;
			ch_sel_q <= ch_sel_d;
			ext_trigger_allow_q <= ext_trigger_allow_d;
			spare_select_bit_q <= spare_select_bit_d;
			armed_q <= armed_d;
			irq_q <= irq_d;
		end
	end

	// =====================================================================
	// Read port
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				adc_seq_pkg::ADDR_RESULT_A: rdata_d = res_q[0];
				adc_seq_pkg::ADDR_RESULT_B: rdata_d = res_q[1];
				adc_seq_pkg::ADDR_RESULT_C: rdata_d = res_q[2];
				adc_seq_pkg::ADDR_RESULT_D: rdata_d = res_q[3];
				adc_seq_pkg::ADDR_CTRL_STATUS: rdata_d = {convert_done_flag_q, done_irq_allow_q,
					convert_go_q, scan_q, conv_speed_select_q, ch_sel_q};
				adc_seq_pkg::ADDR_TRIG_CTRL: rdata_d = adc_seq_pkg::TRIG_FIXED_ONES
					| {ext_trigger_allow_q, 6'h00, spare_select_bit_q}; // [R3]
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign sar_code = sar_q;
	assign analog_sel = sel_q;
	assign sample_hold = hold_q;
	assign convert_done_irq = irq_q;

	// =====================================================================
	// Assertions
	property p_tc_standby;
		@(posedge clk) disable iff (!rst_n)
		standby |=> ext_trigger_allow_q == 1'b0 && spare_select_bit_q == 1'b0;
	endproperty
	a_tc_standby: assert property (p_tc_standby) else $error("trigger control not reset"); // [R1]

	property p_tc_ones;
		@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == adc_seq_pkg::ADDR_TRIG_CTRL |=> reg_rdata[6:1] == 6'h3F;
	endproperty
	a_tc_ones: assert property (p_tc_ones) else $error("reserved bits not read as one"); // [R3]

	property p_single_end;
		@(posedge clk) disable iff (!rst_n)
		single_end && !standby && !wr_cs && !trig_fire |=> !convert_go_q && convert_done_flag_q;
	endproperty
	a_single_end: assert property (p_single_end) else $error("single end not handled"); // [R6]

	property p_irq;
		@(posedge clk) disable iff (!rst_n)
		convert_done_irq == (convert_done_flag_q && done_irq_allow_q);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt request mismatch"); // [R7]

	property p_flag_clear;
		@(posedge clk) disable iff (!rst_n)
		$fell(convert_done_flag_q) |-> $past(standby) || ($past(wr_cs) && $past(armed_q));
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag cleared without read"); // [R8]

	property p_trigger;
		@(posedge clk) disable iff (!rst_n)
		trig_fire && !standby |=> convert_go_q;
	endproperty
	a_trigger: assert property (p_trigger) else $error("external start ignored"); // [R21]

	property p_sync_slow;
		@(posedge clk) disable iff (!rst_n)
		$rose(state_q == adc_seq_pkg::ST_SYNC) && !conv_speed_select_q
		|-> ##[17:32] (state_q != adc_seq_pkg::ST_SYNC);
	endproperty
	a_sync_slow: assert property (p_sync_slow) else $error("sync delay out of range"); // [R17]

	property p_sample_len;
		@(posedge clk) disable iff (!rst_n)
		$fell(sample_hold) && state_q == adc_seq_pkg::ST_CONVERT
		|-> hold_run_q == (conv_speed_select_q ? 8'(adc_seq_pkg::SAMPLE_FAST)
			: 8'(adc_seq_pkg::SAMPLE_SLOW));
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("sample window wrong"); // [R16]

	property p_abort;
		@(posedge clk) disable iff (!rst_n)
		!convert_go_q |-> !conv_end ##1 state_q == adc_seq_pkg::ST_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("conversion not aborted"); // [R27]

endmodule

// >>> bench/analog_source.sv
/*
 Behavioural model of the analog inputs and the comparator in front of them.
 Assumes the block selects a channel on analog_sel and offers a trial code on sar_code.
*/
`timescale 1ns/1ps
module analog_source #(
	parameter logic [63:0] LEVELS = 64'h0
) (
	input wire logic [2:0] analog_sel,
	input wire logic [7:0] sar_code,
	output logic comp_in
);
	// =====================================================================
	// Comparator
	// Each channel holds a fixed level; the reference ends map to codes 00 and FF.
	assign comp_in = (LEVELS[{analog_sel, 3'h0} +: 8] >= sar_code);
endmodule

// >>> bench/adc_sequence_control_tb.sv
/*
 Self-checking testbench for the converter sequencing block.
 Assumes the comparator model in analog_source and a 200 MHz system clock.
*/
`timescale 1ns/1ps
module adc_sequence_control_tb;
	localparam logic [63:0] LEVELS = 64'hFFC3A57F815A3C00;
	localparam logic [15:0] CS = adc_seq_pkg::ADDR_CTRL_STATUS;
	localparam logic [15:0] TC = adc_seq_pkg::ADDR_TRIG_CTRL;
	logic clk, rst_n, standby, reg_wr, reg_rd, ext_start_pin_n, comp_in;
	logic sample_hold, convert_done_irq;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, sar_code, rd;
	logic [2:0] analog_sel;
	int n_errors, checked, cyc, t0, d, p, sh_run, sh_len, sh_start;

	adc_sequence_control i_adc_sequence_control (.clk(clk), .rst_n(rst_n), .standby(standby),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ext_start_pin_n(ext_start_pin_n), .comp_in(comp_in),
		.sar_code(sar_code), .analog_sel(analog_sel), .sample_hold(sample_hold),
		.convert_done_irq(convert_done_irq));
	analog_source #(.LEVELS(LEVELS)) i_analog_source (.analog_sel(analog_sel),
		.sar_code(sar_code), .comp_in(comp_in));

	// =====================================================================
	// Clock, cycle count and sample window measurement
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (sample_hold === 1'b1) begin
			if (sh_run == 0)
				sh_start <= cyc;
			sh_run <= sh_run + 1;
		end else if (sh_run != 0) begin
			sh_len <= sh_run;
			sh_run <= 0;
		end
	end

	// =====================================================================
	// Shared tasks
	function automatic logic [7:0] lv(input int c);
		return LEVELS[c*8 +: 8];
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic in_rng(input int v, input int lo, input int hi);
		chk(8'(v >= lo && v <= hi), 8'h01);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1 t0 = cyc;
	endtask
	task automatic rdr(input logic [15:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
		d = cyc - t0;
	endtask
	task automatic wait_done(input int lim);
		for (int i = 0; i < lim; i++) begin
			rdr(CS);
			if (rd[7] === 1'b1)
				break;
		end
	endtask
	task automatic pin_fall();
		@(posedge clk);
		ext_start_pin_n <= 1'b0;
		repeat (8) @(posedge clk);
		ext_start_pin_n <= 1'b1;
		#1 t0 = cyc - 9;
	endtask

	// =====================================================================
	// Scenarios
	task automatic t_reset();
		for (int i = 0; i < 5; i++) begin
			rdr(16'hFFE0 + 16'(2 * i));
			chk(rd, 8'h00);
		end
		rdr(TC);
		chk(rd, 8'h7E);
		rdr(16'hFFEC);
		chk(rd, 8'h00);
		wr(16'hFFE0, 8'h55);
		rdr(16'hFFE0);
		chk(rd, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_trig();
		wr(TC, 8'h00);
		rdr(TC);
		chk(rd, 8'h7E);
		wr(TC, 8'hFF);
		rdr(TC);
		chk(rd, 8'hFF);
		wr(TC, 8'h01);
		rdr(TC);
		chk(rd, 8'h7F);
		$display("test trigger register done");
	endtask
	task automatic t_single();
		wr(CS, 8'h00);
		wr(CS, 8'h61);
		wait_done(200);
		in_rng(d, 228, 244);
		chk(rd, 8'hC1);
		chk(8'(convert_done_irq), 8'h01);
		chk(8'(sh_len), 8'h3F);
		in_rng(sh_start - t0, 18, 33);
		rdr(adc_seq_pkg::ADDR_RESULT_B);
		chk(rd, lv(1));
		wr(CS, 8'hC1);
		wr(CS, 8'h41);
		rdr(CS);
		chk(rd, 8'hC1);
		wr(CS, 8'h41);
		rdr(CS);
		chk(rd, 8'h41);
		chk(8'(convert_done_irq), 8'h00);
		wr(CS, 8'h00);
		wr(CS, 8'h2E);
		wait_done(100);
		in_rng(d, 116, 124);
		chk(rd, 8'h8E);
		chk(8'(convert_done_irq), 8'h00);
		chk(8'(sh_len), 8'h1F);
		in_rng(sh_start - t0, 10, 17);
		rdr(adc_seq_pkg::ADDR_RESULT_C);
		chk(rd, lv(6));
		wr(CS, 8'h00);
		rdr(CS);
		chk(rd, 8'h00);
		$display("test single done");
	endtask
	task automatic t_scan();
		wr(CS, 8'h36);
		wait_done(450);
		p = cyc;
		in_rng(d, 772, 788);
		chk(rd, 8'hB6);
		for (int i = 0; i < 4; i++) begin
			rdr(16'hFFE0 + 16'(2 * i));
			chk(rd, (i < 3) ? lv(i + 4) : 8'h00);
		end
		wr(CS, 8'h36);
		wait_done(450);
		in_rng(cyc - p, 767, 769);
		repeat (300) @(posedge clk);
		wr(CS, 8'h96);
		repeat (300) @(posedge clk);
		rdr(CS);
		chk(rd, 8'h96);
		wr(CS, 8'h36);
		wait_done(450);
		in_rng(d, 772, 788);
		wr(CS, 8'h00);
		rdr(CS);
		chk(rd, 8'h00);
		$display("test scan done");
	endtask
	task automatic t_ext();
		wr(CS, 8'h01);
		pin_fall();
		rdr(CS);
		chk(rd, 8'h01);
		wr(TC, 8'h80);
		pin_fall();
		rdr(CS);
		chk(rd, 8'h21);
		wait_done(200);
		in_rng(d, 232, 248);
		chk(rd, 8'h81);
		rdr(adc_seq_pkg::ADDR_RESULT_B);
		chk(rd, lv(1));
		$display("test external start done");
	endtask
	task automatic t_standby();
		wr(CS, 8'h00);
		wr(CS, 8'h20);
		repeat (40) @(posedge clk);
		standby <= 1'b1;
		@(posedge clk);
		standby <= 1'b0;
		rdr(CS);
		chk(rd, 8'h00);
		rdr(TC);
		chk(rd, 8'h7E);
		rdr(adc_seq_pkg::ADDR_RESULT_B);
		chk(rd, 8'h00);
		$display("test standby done");
	endtask

	// =====================================================================
	// Verdict, watchdog and main sequence
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end
	initial begin
		{rst_n, standby, reg_wr, reg_rd} = 4'h0;
		ext_start_pin_n = 1'b1;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		{n_errors, checked, cyc, t0, d, p, sh_run, sh_len, sh_start} = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_trig();
		t_single();
		t_scan();
		t_ext();
		t_standby();
		give_verdict();
	end
endmodule
